// ===== core/psc_cfg.svh
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// ==========================================================
// Field positions
`define PSC_CU_LSB      28
`define PSC_CU_MSB      31
`define PSC_RP_BIT      27
`define PSC_FR_BIT      26
`define PSC_RE_BIT      25
`define PSC_MX_BIT      24
`define PSC_PX_BIT      23
`define PSC_BEV_BIT     22
`define PSC_TS_BIT      21
`define PSC_SR_BIT      20
`define PSC_NMI_BIT     19
`define PSC_RSV18_BIT   18
`define PSC_HIM_LSB     10
`define PSC_HIM_MSB     15
`define PSC_SIM_LSB     8
`define PSC_SIM_MSB     9
`define PSC_KX_BIT      7
`define PSC_SX_BIT      6
`define PSC_UX_BIT      5
`define PSC_KSU_LSB     3
`define PSC_KSU_MSB     4
`define PSC_UM_BIT      4

// ==========================================================
// Reset values
`define PSC_BEV_RST     1'b1
`define PSC_TS_RST      1'b0
`define PSC_RP_RST      1'b0
`define PSC_FR_RST      1'b0
`define PSC_CU_RST      4'h0
`define PSC_HIM_RST     6'h00
`define PSC_SIM_RST     2'h0
`define PSC_KSU_RST     2'h0
`define PSC_KSU_RSVD    2'h3

`endif

// ===== core/psc_irq_gate.sv
`timescale 1ns/100ps
`include "psc_cfg.svh"

// ==========================================================
// Interrupt gating: mask mode or priority mode
module psc_irq_gate (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       eic_mode,
  input  wire logic [5:0] hw_mask,
  input  wire logic [1:0] sw_mask,
  input  wire logic [5:0] hw_req,
  input  wire logic [1:0] sw_req,
  input  wire logic [5:0] eic_level,
  output logic            irq_pending
);

  logic pend_nxt;
  logic pend_r;

  always_comb begin
    if (eic_mode) begin
      // Strictly greater; equal level stays quiet
      pend_nxt = (eic_level > hw_mask);
    end else begin
      pend_nxt = |(hw_req & hw_mask) | |(sw_req & sw_mask);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign irq_pending = pend_r;

endmodule

// ===== core/psc_pkg.sv
package psc_pkg;

  typedef enum logic [2:0] {
    PSC_ENTRY_NONE = 3'b001,
    PSC_ENTRY_SOFT = 3'b010,
    PSC_ENTRY_NMI  = 3'b100
  } psc_entry_e;

  typedef enum logic [1:0] {
    PSC_MODE_KERNEL = 2'h0,
    PSC_MODE_SUPER  = 2'h1,
    PSC_MODE_USER   = 2'h2
  } psc_mode_e;

endpackage

// ===== core/psc_status.sv
`timescale 1ns/100ps
`include "psc_cfg.svh"

// Notes on behaviour
// - Coprocessor 0 usable in kernel or debug
// - Coprocessor 1 enable gates all floating point
// - Unconnected coprocessor enables read zero, ignore writes
// - Reduced power resets zero; absent reads zero
// - Wide register mode selects pairing; resets zero
// - Wide mode forced zero without 64-bit unit
// - User mode references use reversed byte order
// - 64-bit-only bits read zero, ignore writes
// - Boot vector select reads zero in reset, bootstrap from first edge after it
// - Multi-match sets flag and machine check
// - Warm restart flag marks soft reset entry
// - NMI flag marks non-maskable entry
// - Bit 18 reads zero
// - Hardware mask bits enable requests
// - Priority mode needs strictly higher request
// - Software masks inert in priority mode
// - Without supervisor, bit 4 sets mode
// - Bit 4 zero kernel, one user
module psc_status #(
  parameter logic [3:0] CU_PRESENT = 4'h3,
  parameter bit         HAS_RP     = 1'b1,
  parameter bit         HAS_FPU64  = 1'b1,
  parameter bit         HAS_RE     = 1'b1,
  parameter bit         HAS_TS     = 1'b1,
  parameter bit         HAS_SUPER  = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  output logic      [31:0] rd_data,
  input  wire logic        debug_mode,
  input  wire logic        exc_level,
  input  wire logic        soft_reset_entry,
  input  wire logic        nmi_entry,
  input  wire logic        tlb_write,
  input  wire logic        tlb_multi_hit,
  input  wire logic        eic_mode,
  input  wire logic [5:0]  hw_req,
  input  wire logic [1:0]  sw_req,
  input  wire logic [5:0]  eic_level,
  input  wire logic        big_endian_cfg,
  output logic             cop0_ok,
  output logic             cop1_ok,
  output logic             fpr_wide_mode,
  output logic             data_big_endian,
  output logic             boot_vector_select,
  output logic             machine_check,
  output logic             reduced_power,
  output logic [1:0]       base_mode,
  output logic             irq_pending
);

  // ==========================================================
  // Stored fields
  logic [3:0] cu_r, cu_nxt;
  logic       rp_r, rp_nxt;
  logic       fr_r, fr_nxt;
  logic       re_r, re_nxt;
  logic       bev_r, bev_nxt;
  logic       ts_r, ts_nxt;
  logic       sr_r, sr_nxt;
  logic       nmi_r, nmi_nxt;
  logic [5:0] him_r, him_nxt;
  logic [1:0] sim_r, sim_nxt;
  logic [1:0] ksu_r, ksu_nxt;
  logic       mc_r, mc_nxt;
  psc_pkg::psc_entry_e entry;

  always_comb begin
    if (nmi_entry) begin
      entry = psc_pkg::PSC_ENTRY_NMI;
    end else if (soft_reset_entry) begin
      entry = psc_pkg::PSC_ENTRY_SOFT;
    end else begin
      entry = psc_pkg::PSC_ENTRY_NONE;
    end
  end

  // ==========================================================
  // Next state
  // Software write is applied first, hardware events after it
  // Ordering keeps flags set by events from being lost
  always_comb begin
    cu_nxt  = cu_r;
    rp_nxt  = rp_r;
    fr_nxt  = fr_r;
    re_nxt  = re_r;
    bev_nxt = bev_r;
    ts_nxt  = ts_r;
    sr_nxt  = sr_r;
    nmi_nxt = nmi_r;
    him_nxt = him_r;
    sim_nxt = sim_r;
    ksu_nxt = ksu_r;
    mc_nxt  = 1'b0;
    if (wr_en) begin
      // Absent coprocessors keep zero
      cu_nxt  = wr_data[`PSC_CU_MSB:`PSC_CU_LSB] & CU_PRESENT;
      rp_nxt  = wr_data[`PSC_RP_BIT] & HAS_RP;
      fr_nxt  = wr_data[`PSC_FR_BIT] & HAS_FPU64;
      re_nxt  = wr_data[`PSC_RE_BIT] & HAS_RE;
      bev_nxt = wr_data[`PSC_BEV_BIT];
      // A software 0-to-1 write is accepted silently
      ts_nxt  = wr_data[`PSC_TS_BIT] & HAS_TS;
      sr_nxt  = wr_data[`PSC_SR_BIT];
      nmi_nxt = wr_data[`PSC_NMI_BIT];
      him_nxt = wr_data[`PSC_HIM_MSB:`PSC_HIM_LSB];
      sim_nxt = wr_data[`PSC_SIM_MSB:`PSC_SIM_LSB];
      if (HAS_SUPER) begin
        ksu_nxt = wr_data[`PSC_KSU_MSB:`PSC_KSU_LSB];
      end else begin
        ksu_nxt = {wr_data[`PSC_UM_BIT], 1'b0};
      end
    end
    // Hardware events win over a same-cycle software write
    unique case (entry)
      psc_pkg::PSC_ENTRY_SOFT: begin
        sr_nxt  = 1'b1;
        nmi_nxt = 1'b0;
      end
      psc_pkg::PSC_ENTRY_NMI: begin
        sr_nxt  = 1'b0;
        nmi_nxt = 1'b1;
      end
      psc_pkg::PSC_ENTRY_NONE: begin
      end
    endcase
    // Detection only counts on TLB writes
    if (HAS_TS && tlb_multi_hit && tlb_write) begin
      ts_nxt = 1'b1;
      mc_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cu_r  <= `PSC_CU_RST;
      rp_r  <= `PSC_RP_RST;
      fr_r  <= `PSC_FR_RST;
      re_r  <= 1'b0;
      bev_r <= `PSC_BEV_RST;
      ts_r  <= `PSC_TS_RST;
      sr_r  <= 1'b0;
      nmi_r <= 1'b0;
      him_r <= `PSC_HIM_RST;
      sim_r <= `PSC_SIM_RST;
      ksu_r <= `PSC_KSU_RST;
      mc_r  <= 1'b0;
    end else begin
      cu_r  <= cu_nxt;
      rp_r  <= rp_nxt;
      fr_r  <= fr_nxt;
      re_r  <= re_nxt;
      bev_r <= bev_nxt;
      ts_r  <= ts_nxt;
      sr_r  <= sr_nxt;
      nmi_r <= nmi_nxt;
      him_r <= him_nxt;
      sim_r <= sim_nxt;
      ksu_r <= ksu_nxt;
      mc_r  <= mc_nxt;
    end
  end

  // ==========================================================
  // Readback and derived outputs, all registered
  logic [31:0] rd_nxt, rd_r;
  logic        user_now;
  logic        c0_nxt, c1_nxt, end_nxt;
  logic        c0_r, c1_r, end_r;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_nxt[`PSC_CU_MSB:`PSC_CU_LSB]   = cu_nxt;
    rd_nxt[`PSC_RP_BIT]               = rp_nxt;
    rd_nxt[`PSC_FR_BIT]               = fr_nxt;
    rd_nxt[`PSC_RE_BIT]               = re_nxt;
    rd_nxt[`PSC_BEV_BIT]              = bev_nxt;
    rd_nxt[`PSC_TS_BIT]               = ts_nxt;
    rd_nxt[`PSC_SR_BIT]               = sr_nxt;
    rd_nxt[`PSC_NMI_BIT]              = nmi_nxt;
    rd_nxt[`PSC_RSV18_BIT]            = 1'b0;
    rd_nxt[`PSC_HIM_MSB:`PSC_HIM_LSB] = him_nxt;
    rd_nxt[`PSC_SIM_MSB:`PSC_SIM_LSB] = sim_nxt;
    rd_nxt[`PSC_KSU_MSB:`PSC_KSU_LSB] = ksu_nxt;
    // Kernel when base mode is zero or exception level set
    user_now = (ksu_nxt != 2'h0) && !exc_level && !debug_mode;
    c0_nxt   = !user_now || cu_nxt[0];
    c1_nxt   = cu_nxt[1];
    end_nxt  = big_endian_cfg ^ (user_now && ksu_nxt[1] && re_nxt);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_r  <= 32'h0000_0000;
      c0_r  <= 1'b1;
      c1_r  <= 1'b0;
      end_r <= 1'b0;
    end else begin
      rd_r  <= rd_nxt;
      c0_r  <= c0_nxt;
      c1_r  <= c1_nxt;
      end_r <= end_nxt;
    end
  end

  assign rd_data            = rd_r;
  assign cop0_ok            = c0_r;
  assign cop1_ok            = c1_r;
  assign fpr_wide_mode      = rd_r[`PSC_FR_BIT];
  assign data_big_endian    = end_r;
  assign boot_vector_select = rd_r[`PSC_BEV_BIT];
  assign machine_check      = mc_r;
  assign reduced_power      = rd_r[`PSC_RP_BIT];
  assign base_mode          = rd_r[`PSC_KSU_MSB:`PSC_KSU_LSB];

  // ==========================================================
  // Interrupt gate
  psc_irq_gate u_gate (
    .clk         (clk),
    .rst         (rst),
    .eic_mode    (eic_mode),
    .hw_mask     (him_r),
    .sw_mask     (sim_r),
    .hw_req      (hw_req),
    .sw_req      (sw_req),
    .eic_level   (eic_level),
    .irq_pending (irq_pending)
  );

endmodule

// ===== tb/psc_status_props.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker for the status register
module psc_status_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wr_en,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] rd_data,
  input wire logic        debug_mode,
  input wire logic        soft_reset_entry,
  input wire logic        nmi_entry,
  input wire logic        tlb_write,
  input wire logic        tlb_multi_hit,
  input wire logic        eic_mode,
  input wire logic [5:0]  hw_req,
  input wire logic [1:0]  sw_req,
  input wire logic [5:0]  eic_level,
  input wire logic        cop0_ok,
  input wire logic        machine_check,
  input wire logic        irq_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Read image updates on the same edge as the register; the two-cycle waits only add margin
  sequence tlb_hit_s;
    tlb_write && tlb_multi_hit;
  endsequence
  sequence eic_above_s;
    (eic_mode && eic_level > rd_data[15:10])[*3];
  endsequence
  sequence eic_below_s;
    (eic_mode && eic_level <= rd_data[15:10])[*3];
  endsequence
  sequence masked_s;
    (!eic_mode && (hw_req & rd_data[15:10]) == 6'h00
      && (sw_req & rd_data[9:8]) == 2'h0)[*3];
  endsequence
  chk_rsvd_zero: assert property (
    {rd_data[24:23], rd_data[18], rd_data[7:5]} == 6'h00)
    else $error("reserved status bit set");
  chk_cu_absent: assert property (
    rd_data[31:30] == 2'h0) else $error("absent enable bit set");
  chk_cop0_debug: assert property (
    debug_mode |=> cop0_ok) else $error("cop0 blocked in debug");
  chk_bev_write: assert property (
    wr_en |-> ##2 rd_data[22] == $past(wr_data[22], 2))
    else $error("boot vector select not written");
  chk_tlb_flag: assert property (
    tlb_hit_s |-> ##1 machine_check && rd_data[21])
    else $error("multi match not flagged");
  chk_mc_cause: assert property (
    $rose(machine_check) |-> $past(tlb_write) && $past(tlb_multi_hit))
    else $error("machine check without cause");
  chk_soft_entry: assert property (
    soft_reset_entry && !nmi_entry |-> ##2 rd_data[20:19] == 2'h2)
    else $error("soft entry flags wrong");
  chk_nmi_entry: assert property (
    nmi_entry |-> ##2 rd_data[20:19] == 2'h1)
    else $error("nmi entry flags wrong");
  chk_irq_above: assert property (
    eic_above_s |-> irq_pending) else $error("priority irq missing");
  chk_irq_below: assert property (
    eic_below_s |-> !irq_pending) else $error("priority irq not held");
  chk_mask_block: assert property (
    masked_s |-> !irq_pending) else $error("masked irq raised");
endmodule

bind psc_status psc_status_props psc_status_props_i (
  .clk(clk), .rst(rst), .wr_en(wr_en), .wr_data(wr_data),
  .rd_data(rd_data), .debug_mode(debug_mode),
  .soft_reset_entry(soft_reset_entry), .nmi_entry(nmi_entry),
  .tlb_write(tlb_write), .tlb_multi_hit(tlb_multi_hit),
  .eic_mode(eic_mode), .hw_req(hw_req), .sw_req(sw_req),
  .eic_level(eic_level), .cop0_ok(cop0_ok),
  .machine_check(machine_check), .irq_pending(irq_pending)
);

// ===== tb/tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench for the status register
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, wr_en = 1'b0, eic_mode = 1'b0;
  logic        debug_mode = 1'b0, exc_level = 1'b0, big_endian_cfg = 1'b0;
  logic        soft_reset_entry = 1'b0, nmi_entry = 1'b0;
  logic        tlb_write = 1'b0, tlb_multi_hit = 1'b0;
  logic [31:0] wr_data = 32'h00000000;
  logic [5:0]  hw_req = 6'h00, eic_level = 6'h00;
  logic [1:0]  sw_req = 2'h0;
  logic [31:0] rd_data;
  logic        cop0_ok, cop1_ok, fpr_wide_mode, data_big_endian;
  logic        boot_vector_select, machine_check, reduced_power, irq_pending;
  logic [1:0]  base_mode;
  int          err_count = 0, n_compared = 0, mc_seen = 0;

  always #50 clk = ~clk;
  always @(posedge clk) if (machine_check === 1'b1) mc_seen <= mc_seen + 1;

  psc_status psc_status_i (
    .clk(clk), .rst(rst), .wr_en(wr_en), .wr_data(wr_data),
    .rd_data(rd_data), .debug_mode(debug_mode), .exc_level(exc_level),
    .soft_reset_entry(soft_reset_entry), .nmi_entry(nmi_entry),
    .tlb_write(tlb_write), .tlb_multi_hit(tlb_multi_hit),
    .eic_mode(eic_mode), .hw_req(hw_req), .sw_req(sw_req),
    .eic_level(eic_level), .big_endian_cfg(big_endian_cfg),
    .cop0_ok(cop0_ok), .cop1_ok(cop1_ok), .fpr_wide_mode(fpr_wide_mode),
    .data_big_endian(data_big_endian),
    .boot_vector_select(boot_vector_select),
    .machine_check(machine_check), .reduced_power(reduced_power),
    .base_mode(base_mode), .irq_pending(irq_pending)
  );

  // ==========================================================
  // Shared drivers
  task automatic stp(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Waits two more edges after the write before anything is judged
  task automatic wr(input logic [31:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    stp(2);
  endtask
  task automatic ev(input logic [3:0] v);
    @(posedge clk);
    {soft_reset_entry, nmi_entry, tlb_write, tlb_multi_hit} <= v;
    @(posedge clk);
    {soft_reset_entry, nmi_entry, tlb_write, tlb_multi_hit} <= 4'h0;
    stp(2);
  endtask
  task automatic ck(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic ir(input logic m, input logic [5:0] h, input logic [1:0] s,
                    input logic [5:0] l, input logic e);
    @(posedge clk);
    eic_mode  <= m;
    hw_req    <= h;
    sw_req    <= s;
    eic_level <= l;
    stp(3);
    ck("irq_pending", e, irq_pending);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    ck("status", 32'h00400000, rd_data);
    ck("cop0_ok", 1'b1, cop0_ok);
  endtask
  task automatic t_fields();
    wr(32'hEFC7FFF7);
    ck("status", 32'h2E40FF10, rd_data);
    ck("outs", 6'h3E, {fpr_wide_mode, reduced_power, cop1_ok,
       boot_vector_select, base_mode});
    ck("endian", 1'b1, data_big_endian);
    ck("cop0_ok", 1'b0, cop0_ok);
    @(posedge clk);
    debug_mode <= 1'b1;
    stp(2);
    ck("cop0_ok", 1'b1, cop0_ok);
    ck("endian", 1'b0, data_big_endian);
    @(posedge clk);
    debug_mode <= 1'b0;
    exc_level  <= 1'b1;
    stp(2);
    ck("cop0_ok", 1'b1, cop0_ok);
    @(posedge clk);
    exc_level <= 1'b0;
  endtask
  task automatic t_b2b();
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_data <= 32'h04000000;
    @(posedge clk);
    wr_data <= 32'h00000400;
    @(posedge clk);
    wr_en <= 1'b0;
    stp(2);
    ck("status", 32'h00000400, rd_data);
    ck("cop", 2'h1, {cop1_ok, cop0_ok});
  endtask
  task automatic t_entry();
    ev(4'h8);
    ck("entry", 2'h2, rd_data[20:19]);
    ev(4'h4);
    ck("entry", 2'h1, rd_data[20:19]);
    ev(4'hC);
    ck("entry", 2'h1, rd_data[20:19]);
  endtask
  task automatic t_tlb();
    int m0;
    m0 = mc_seen;
    ev(4'h1);
    ck("tlb_flag", 1'b0, rd_data[21]);
    ev(4'h3);
    ck("tlb_flag", 1'b1, rd_data[21]);
    ck("mc_pulses", 1, mc_seen - m0);
    wr(32'h00000400);
    ck("tlb_flag", 1'b0, rd_data[21]);
  endtask
  task automatic t_irq();
    wr(32'h00000500);
    ir(1'b0, 6'h01, 2'h0, 6'h00, 1'b1);
    ir(1'b0, 6'h02, 2'h0, 6'h00, 1'b0);
    ir(1'b0, 6'h00, 2'h1, 6'h00, 1'b1);
    ir(1'b0, 6'h00, 2'h2, 6'h00, 1'b0);
    wr(32'h00001500);
    ir(1'b1, 6'h00, 2'h1, 6'h05, 1'b0);
    ir(1'b1, 6'h00, 2'h0, 6'h06, 1'b1);
    ir(1'b1, 6'h00, 2'h0, 6'h04, 1'b0);
  endtask

  // ==========================================================
  // Sequence and verdict
  task automatic results();
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    stp(2);
    t_reset();
    t_fields();
    t_b2b();
    t_entry();
    t_tlb();
    t_irq();
    results();
  end
  // Whole run needs about 80 cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    results();
  end
endmodule
